// File: tape_ctl_map.svh
// Offsets, mark codes, widths and counts of the tape word control
`ifndef TAPE_CTL_MAP_SVH
`define TAPE_CTL_MAP_SVH

// ==========================================================
// Word and window geometry
`define WORD_W 18
`define WIN_W 8
`define LANES 3
`define SYNC_STAGES 2
`define FIFO_DEPTH 4

// ==========================================================
// Mark codes, six bits as seen in the window low end
`define CODE_DATA 6'h38
`define CODE_BLOCK 6'h16
`define CODE_BLOCK_REV 6'h25
`define CODE_PREFINAL 6'h08

// Tail of the preceding mark that makes each code legitimate
`define TAIL_DATA 2'h0
`define TAIL_BLOCK 2'h1
`define TAIL_PREFINAL 2'h0

// End zones: repeating patterns of period three, full window
`define END_FWD_A 8'hB6
`define END_FWD_B 8'h6D
`define END_FWD_C 8'hDB
`define END_REV_A 8'h49
`define END_REV_B 8'h92
`define END_REV_C 8'h24

// Mark number field of the assembled word
`define MARKNUM_MSB 11
`define MARKNUM_LSB 0

`endif

// File: tape_ctl_pkg.sv
// Types shared by the tape word control
package tape_ctl_pkg;

   // ==========================================================
   // Programmed mode of operation
   typedef enum logic [1:0] {
      MODE_MOVE = 2'h0,
      MODE_SEARCH = 2'h1,
      MODE_READ = 2'h2,
      MODE_WRITE = 2'h3
   } mode_t;

   // ==========================================================
   // Motion state, one-hot
   typedef enum logic [2:0] {
      MOT_STOP = 3'b001,
      MOT_FWD = 3'b010,
      MOT_REV = 3'b100
   } motion_t;

endpackage

// File: pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Asynchronous pins and their synchronised copy
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   generate
      if (WIDTH < 1) begin : g_bad
         $error("pin_sync needs WIDTH of at least one");
      end
   endgenerate

   // First stage feeds only the second
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= pin_i;
         sync_o <= stage1;
      end
   end

endmodule // pin_sync

// File: word_fifo.sv
// Small word FIFO with valid and ready on both sides
`timescale 1ns/1ns
module word_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
         $error("word_fifo needs DEPTH a power of two, at least two");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   // Honest full and empty
   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];

   // Storage
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule // word_fifo

// File: tape_word_control.sv
// Tape word control: word assembly, interchange and mark track decoding
// What this block does
// - Word register shifts the other way in reverse, keeping each word's bit order.
// - Reverse reading delivers words last-written first, each word intact.
// - Only the end mark ahead in the current direction is honoured.
// - In normal modes the honoured end mark stops motion and sets error.
// - Coasting or turning in an end zone raises no error.
// - End marks still decode after any three-bit shift in the window.
// - Format track write mode detects no marks, flags or end stops.
// - Marks decode only while the transport is selected.
// - No fixed word count per block; flags follow marks alone.
// - Repeated 01 gap codes between blocks raise no flags.
// - Host presents write words on eighteen one-way input lines.
// - Read words return on a separate set of eighteen output lines.
// - Interchange pulse swaps in-out and shift registers in one step.
// - Writing shifts bits out to writers; reading shifts tape bits in.
// - Bit strobes come from timing track edges and step tape-side logic.
// - Mark decoding yields data, block-end flags, breaks and mark numbers.
// - Mark window is eight bits, one new bit per bit-centre strobe.
// - Format track write enable holds the mark window still.
// - A mark counts only after a legitimate tail of the previous mark.
// - Paired codes are complements of each other read bit-reversed.
`timescale 1ns/1ns
`include "tape_ctl_map.svh"
module tape_word_control #(
   parameter int WORD_W = `WORD_W,
   parameter int LANES = `LANES,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Tape pins
   input wire logic timing_track_i,
   input wire logic mark_track_i,
   input wire logic [LANES-1:0] read_bits_i,
   output logic [LANES-1:0] write_bits_o,
   output logic writer_enable_o,
   output logic motion_o,
   output logic reverse_o,
   // Host mode and motion control
   input wire tape_ctl_pkg::mode_t mode_i,
   input wire logic format_track_write_mode_i,
   input wire logic format_track_write_enable_i,
   input wire logic selected_i,
   input wire logic go_i,
   input wire logic stop_i,
   input wire logic reverse_cmd_i,
   input wire logic error_clear_i,
   // Host write words
   input wire logic [WORD_W-1:0] wr_data_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   // Host read words and mark number
   output logic [WORD_W-1:0] rd_data_o,
   output logic [11:0] mark_number_o,
   // Host flags
   output logic data_flag_o,
   output logic block_end_flag_o,
   output logic break_req_o,
   output logic error_flag_o
);

   // ==========================================================
   // Elaboration checks
   generate
      if (WORD_W % LANES != 0) begin : g_bad_word
         $error("word width must be a whole number of lane groups");
      end
      if (WORD_W <= `MARKNUM_MSB) begin : g_bad_marknum
         $error("word too narrow for the mark number field");
      end
   endgenerate

   // ==========================================================
   // Functions

   // Reverse bit order of one lane group
   function automatic logic [LANES-1:0] flip_lanes(input logic [LANES-1:0] v);
      logic [LANES-1:0] r;
      r = '0;
      for (int i = 0; i < LANES; i++) begin
         r[i] = v[LANES-1-i];
      end
      return r;
   endfunction

   // Legitimate mark: code in low six bits, tail of the previous mark above
   function automatic logic mark_match(input logic [`WIN_W-1:0] win,
                                       input logic [5:0] code,
                                       input logic [1:0] tail);
      return (win[5:0] == code) && (win[7:6] == tail);
   endfunction

   // End pattern matches any of its three-bit shifted forms
   function automatic logic end_match(input logic [`WIN_W-1:0] win,
                                      input logic [`WIN_W-1:0] a,
                                      input logic [`WIN_W-1:0] b,
                                      input logic [`WIN_W-1:0] c);
      return (win == a) || (win == b) || (win == c);
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [LANES+1:0] pins_sync;
   logic tt_sync;
   logic mt_sync;
   logic [LANES-1:0] rd_sync;

   pin_sync #(
      .WIDTH(LANES + 2)
   ) u_pin_sync (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .pin_i({timing_track_i, mark_track_i, read_bits_i}),
      .sync_o(pins_sync)
   );

   assign tt_sync = pins_sync[LANES+1];
   assign mt_sync = pins_sync[LANES];
   assign rd_sync = pins_sync[LANES-1:0];

   // ==========================================================
   // Bit strobes from timing track edges
   logic tt_prev;
   logic bit_center_strobe;
   logic between_bit_strobe;

   assign bit_center_strobe = tt_prev && !tt_sync;
   assign between_bit_strobe = !tt_prev && tt_sync;

   // Edge memory
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         tt_prev <= 1'b0;
      end else begin
         tt_prev <= tt_sync;
      end
   end

   // ==========================================================
   // Motion direction state
   tape_ctl_pkg::motion_t motion;
   tape_ctl_pkg::motion_t next_motion;
   logic end_stop;
   logic is_fwd;
   logic is_rev;

   assign is_fwd = (motion == tape_ctl_pkg::MOT_FWD);
   assign is_rev = (motion == tape_ctl_pkg::MOT_REV);

   always_comb begin
      next_motion = motion;
      unique case (motion)
         tape_ctl_pkg::MOT_STOP: begin
            if (go_i && !stop_i) begin
               next_motion = reverse_cmd_i ? tape_ctl_pkg::MOT_REV : tape_ctl_pkg::MOT_FWD;
            end
         end
         tape_ctl_pkg::MOT_FWD, tape_ctl_pkg::MOT_REV: begin
            if (stop_i || end_stop) begin
               next_motion = tape_ctl_pkg::MOT_STOP;
            end else if (go_i) begin
               next_motion = reverse_cmd_i ? tape_ctl_pkg::MOT_REV : tape_ctl_pkg::MOT_FWD;
            end
         end
         default: next_motion = tape_ctl_pkg::MOT_STOP;
      endcase
   end

   // Motion register
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         motion <= tape_ctl_pkg::MOT_STOP;
      end else begin
         motion <= next_motion;
      end
   end

   assign motion_o = !is_fwd ? is_rev : 1'b1;
   assign reverse_o = is_rev;

   // ==========================================================
   // Mark window
   logic [`WIN_W-1:0] window;
   logic window_step;

   assign window_step = bit_center_strobe && !format_track_write_enable_i;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         window <= '0;
      end else if (window_step) begin
         window <= {window[`WIN_W-2:0], mt_sync};
      end
   end

   // ==========================================================
   // Mark decoding
   logic decode_ok;
   logic hit_data;
   logic hit_block;
   logic hit_prefinal;
   logic hit_end_fwd;
   logic hit_end_rev;
   logic normal_mode;
   logic inspect;
   logic window_shifted;

   // no marks while writing the format tracks
   assign normal_mode = !format_track_write_mode_i;
   // decode only on the selected transport
   assign decode_ok = normal_mode && selected_i;
   // Inspect the window the cycle after it stepped
   assign inspect = decode_ok && window_shifted;

   assign hit_data = inspect && mark_match(window, `CODE_DATA, `TAIL_DATA);
   // block mark seen either way round
   assign hit_block = inspect && (mark_match(window, `CODE_BLOCK, `TAIL_BLOCK)
                                  || mark_match(window, `CODE_BLOCK_REV, `TAIL_BLOCK));
   assign hit_prefinal = inspect && mark_match(window, `CODE_PREFINAL, `TAIL_PREFINAL);
   // gap pattern matches no code above
   // end marks in every three-bit shift
   assign hit_end_fwd = inspect && end_match(window, `END_FWD_A, `END_FWD_B, `END_FWD_C);
   assign hit_end_rev = inspect && end_match(window, `END_REV_A, `END_REV_B, `END_REV_C);

   // only the end ahead of motion
   // no error while stopped or heading out of the zone
   assign end_stop = (hit_end_fwd && is_fwd) || (hit_end_rev && is_rev);

   // Delay the window step by one cycle for inspection
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         window_shifted <= 1'b0;
      end else begin
         window_shifted <= window_step;
      end
   end

   // ==========================================================
   // Error flag
   // end mark stops tape and sets error; set beats clear
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         error_flag_o <= 1'b0;
      end else if (end_stop) begin
         error_flag_o <= 1'b1;
      end else if (error_clear_i) begin
         error_flag_o <= 1'b0;
      end
   end

   // ==========================================================
   // Write word buffer and in-out register
   logic [WORD_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_take;
   logic io_full;
   logic [WORD_W-1:0] io_reg;
   logic [WORD_W-1:0] shift_reg;
   logic is_write;
   logic is_read;
   logic is_search;
   logic interchange;

   assign is_write = (mode_i == tape_ctl_pkg::MODE_WRITE);
   assign is_read = (mode_i == tape_ctl_pkg::MODE_READ);
   assign is_search = (mode_i == tape_ctl_pkg::MODE_SEARCH);

   // host words enter through the buffer
   word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_word_fifo (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .in_data_i(wr_data_i),
      .in_valid_i(wr_valid_i),
      .in_ready_o(wr_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_take)
   );

   // Buffer drains only into an empty in-out register in write mode
   assign fifo_take = is_write && !io_full && !interchange;

   // interchange on each data mark in read or write
   // word boundaries come from marks, never a count
   assign interchange = hit_data && (is_read || is_write);

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         io_reg <= '0;
         io_full <= 1'b0;
      end else if (interchange) begin
         io_reg <= shift_reg;
         io_full <= 1'b0;
      end else if (fifo_take && fifo_valid) begin
         io_reg <= fifo_data;
         io_full <= 1'b1;
      end
   end

   // ==========================================================
   // Serial shift register
   logic [WORD_W-1:0] next_shift;
   logic [LANES-1:0] lanes_in;

   // write shifts out, read shifts tape bits in
   assign lanes_in = is_write ? '0 : rd_sync;

   always_comb begin
      next_shift = shift_reg;
      if (interchange) begin
         next_shift = io_reg;
      end else if (bit_center_strobe && is_rev) begin
         next_shift = {flip_lanes(lanes_in), shift_reg[WORD_W-1:LANES]};
      end else if (bit_center_strobe && is_fwd) begin
         next_shift = {shift_reg[WORD_W-LANES-1:0], lanes_in};
      end
   end

   // Shift register
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         shift_reg <= '0;
      end else begin
         shift_reg <= next_shift;
      end
   end

   // writers load on the between-bit strobe
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         write_bits_o <= '0;
      end else if (between_bit_strobe && is_write) begin
         write_bits_o <= is_rev ? flip_lanes(shift_reg[LANES-1:0])
                                : shift_reg[WORD_W-1:WORD_W-LANES];
      end
   end

   // Writers on only in write mode of a normal, selected transport
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         writer_enable_o <= 1'b0;
      end else begin
         writer_enable_o <= is_write && decode_ok;
      end
   end

   // ==========================================================
   // Host read side and flags
   // read words on their own lines
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rd_data_o <= '0;
      end else if (interchange && is_read) begin
         rd_data_o <= shift_reg;
      end
   end

   // block mark number held for the host
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         mark_number_o <= '0;
      end else if (hit_block && is_search) begin
         mark_number_o <= shift_reg[`MARKNUM_MSB:`MARKNUM_LSB];
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         data_flag_o <= 1'b0;
         block_end_flag_o <= 1'b0;
         break_req_o <= 1'b0;
      end else begin
         data_flag_o <= interchange || (hit_block && is_search);
         block_end_flag_o <= hit_prefinal && (is_read || is_write);
         break_req_o <= interchange || (hit_block && is_search)
                        || (hit_prefinal && (is_read || is_write)) || end_stop;
      end
   end

endmodule // tape_word_control

// File: tape_word_control_props.sv
// Concurrent checks on the ports of the tape word control
`timescale 1ns/1ns
module tape_word_control_props (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Host controls
   input wire logic format_track_write_mode_i,
   input wire logic selected_i,
   input wire logic go_i,
   input wire logic stop_i,
   input wire logic reverse_cmd_i,
   input wire logic error_clear_i,
   // Observed outputs
   input wire logic motion_o,
   input wire logic reverse_o,
   input wire logic data_flag_o,
   input wire logic block_end_flag_o,
   input wire logic break_req_o,
   input wire logic error_flag_o
);
   // ==========================================================
   // Helper: cycles in a row without mark decoding allowed
   logic [2:0] quiet_cnt;
   wire logic quiet_now = format_track_write_mode_i | ~selected_i;
   always_ff @(posedge clock_i) begin
      if (srst_i | ~quiet_now) begin
         quiet_cnt <= 3'h0;
      end else if (quiet_cnt != 3'h7) begin
         quiet_cnt <= quiet_cnt + 3'h1;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // Checks on flags, motion and error
   AST_RESET_IDLE: assert property (disable iff (1'h0) srst_i |=> !motion_o && !error_flag_o && !break_req_o)
      else $error("outputs not idle after reset");
   AST_DATA_PULSE: assert property (data_flag_o |=> !data_flag_o)
      else $error("data flag longer than one cycle");
   AST_FLAG_BREAK: assert property ((data_flag_o || block_end_flag_o) |-> break_req_o)
      else $error("flag without break request");
   AST_QUIET: assert property (quiet_cnt >= 3'h6 |-> !data_flag_o && !block_end_flag_o && !$rose(error_flag_o))
      else $error("mark decoded while format mode or deselected");
   AST_GO_FWD: assert property (go_i && !stop_i && !reverse_cmd_i |=> motion_o && !reverse_o)
      else $error("forward go not obeyed");
   AST_GO_REV: assert property (go_i && !stop_i && reverse_cmd_i |=> motion_o && reverse_o)
      else $error("reverse go not obeyed");
   AST_STOP: assert property (stop_i |=> !motion_o)
      else $error("stop not obeyed");
   AST_ERR_HALTS: assert property ($rose(error_flag_o) |-> !motion_o)
      else $error("error raised while still moving");
   AST_ERR_HOLD: assert property (error_flag_o && !error_clear_i |=> error_flag_o)
      else $error("error flag dropped without clear");
   AST_ERR_CLEAR: assert property (error_flag_o && error_clear_i && !motion_o |=> !error_flag_o)
      else $error("error flag not cleared");
   AST_REV_MOVING: assert property (reverse_o |-> motion_o)
      else $error("reverse shown while stopped");
endmodule // tape_word_control_props

bind tape_word_control tape_word_control_props u_props (.clock_i(clock_i), .srst_i(srst_i),
   .format_track_write_mode_i(format_track_write_mode_i), .selected_i(selected_i), .go_i(go_i),
   .stop_i(stop_i), .reverse_cmd_i(reverse_cmd_i), .error_clear_i(error_clear_i), .motion_o(motion_o),
   .reverse_o(reverse_o), .data_flag_o(data_flag_o), .block_end_flag_o(block_end_flag_o),
   .break_req_o(break_req_o), .error_flag_o(error_flag_o));

// File: tape_feed.sv
// Tape transport model driving the timing, mark and data track pins
`timescale 1ns/1ns
module tape_feed (
   // Clock
   input wire logic clock_i,
   // Track pins toward the control
   output logic timing_o,
   output logic mark_o,
   output logic [2:0] lanes_o
);
   initial begin
      timing_o = 1'h1;
      mark_o = 1'h0;
      lanes_o = 3'h0;
   end
   // ==========================================================
   // timing edges spaced, lines flip at the rising timing edge
   task automatic send_bit(input logic m, input logic [2:0] l);
      @(posedge clock_i);
      #1;
      mark_o = m;
      lanes_o = l;
      repeat (4) @(posedge clock_i);
      #1 timing_o = 1'h0;
      repeat (5) @(posedge clock_i);
      #1 timing_o = 1'h1;
      mark_o = ~m;
      lanes_o = ~l;
      repeat (5) @(posedge clock_i);
      #1;
   endtask
   task automatic send_frame(input logic [7:0] w, input logic [17:0] d, input logic rev);
      logic [2:0] l;
      for (int i = 0; i < 8; i++) begin
         l = 3'h0;
         if (i >= 2 && !rev) l = d[17-3*(i-2) -: 3];
         if (i >= 2 && rev) l = {d[3*(i-2)], d[3*(i-2)+1], d[3*(i-2)+2]};
         send_bit(w[7-i], l);
      end
   endtask
endmodule // tape_feed

// File: tape_word_control_test.sv
// Self-checking bench for the tape word control
`timescale 1ns/1ns
module tape_word_control_test;
   logic clock_i = 1'h0;
   logic srst_i = 1'h1;
   logic timing, mark, fmt = 1'h0, sel = 1'h1, go = 1'h0, stop = 1'h0, rev = 1'h0, clr = 1'h0;
   logic [2:0] lanes, wbits;
   tape_ctl_pkg::mode_t mode = tape_ctl_pkg::MODE_READ;
   logic [17:0] wr_data = 18'h0, rd_data;
   logic wr_valid = 1'h0;
   logic wr_ready, wen, moving, back, dflag, bflag, brk, err;
   logic [11:0] mnum;
   logic [7:0] fwd_end [3] = '{8'hB6, 8'h6D, 8'hDB};
   logic [7:0] rev_end [3] = '{8'h49, 8'h92, 8'h24};
   int n_fail = 0, n_tests = 0, n_data = 0, n_blk = 0;
   // ==========================================================
   // Clock and flag pulse counting
   always #20 clock_i = ~clock_i;
   always @(negedge clock_i) begin
      if (dflag === 1'h1) n_data++;
      if (bflag === 1'h1) n_blk++;
   end
   tape_feed u_tape_feed (.clock_i(clock_i), .timing_o(timing), .mark_o(mark), .lanes_o(lanes));
   tape_word_control u_tape_word_control (.clock_i(clock_i), .srst_i(srst_i), .timing_track_i(timing),
      .mark_track_i(mark), .read_bits_i(lanes), .write_bits_o(wbits), .writer_enable_o(wen),
      .motion_o(moving), .reverse_o(back), .mode_i(mode), .format_track_write_mode_i(fmt),
      .format_track_write_enable_i(fmt), .selected_i(sel), .go_i(go), .stop_i(stop),
      .reverse_cmd_i(rev), .error_clear_i(clr), .wr_data_i(wr_data), .wr_valid_i(wr_valid),
      .wr_ready_o(wr_ready), .rd_data_o(rd_data), .mark_number_o(mnum), .data_flag_o(dflag),
      .block_end_flag_o(bflag), .break_req_o(brk), .error_flag_o(err));
   function automatic logic [17:0] wdat(input int i);
      return 18'h2C3A5 ^ (18'h0491D << i);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Go in a direction, or stop
   task automatic motion(input logic r, input logic s);
      rev = r;
      go = ~s;
      stop = s;
      @(posedge clock_i);
      #1 go = 1'h0;
      stop = 1'h0;
   endtask
   task automatic clear_err;
      clr = 1'h1;
      @(posedge clock_i);
      #1 clr = 1'h0;
   endtask
   // blocks of one to three words
   task automatic t_read_fwd;
      motion(1'h0, 1'h0);
      check("moving", moving, 1);
      for (int n = 1; n <= 3; n++) begin
         n_data = 0;
         n_blk = 0;
         for (int k = 0; k < n; k++) begin
            u_tape_feed.send_frame(8'h38, wdat(k), 1'h0);
            check("rd_data", rd_data, wdat(k));
         end
         u_tape_feed.send_frame(8'h08, 18'h0, 1'h0);
         check("data_flags", n_data, n);
         check("block_ends", n_blk, 1);
      end
      $display("Test read_fwd done");
   endtask
   task automatic t_read_rev;
      motion(1'h1, 1'h0);
      check("reverse", back, 1);
      for (int k = 1; k >= 0; k--) begin
         u_tape_feed.send_frame(8'h38, wdat(k), 1'h1);
         check("rev_word", rd_data, wdat(k));
      end
      $display("Test read_rev done");
   endtask
   task automatic t_search;
      mode = tape_ctl_pkg::MODE_SEARCH;
      motion(1'h0, 1'h0);
      n_data = 0;
      u_tape_feed.send_frame(8'h56, wdat(5), 1'h0);
      check("search_flag", n_data, 1);
      check("mark_number", mnum, 18'h00FFF & wdat(5));
      u_tape_feed.send_frame(8'h65, wdat(6), 1'h0);
      check("obverse_flag", n_data, 2);
      check("obverse_number", mnum, 18'h00FFF & wdat(6));
      mode = tape_ctl_pkg::MODE_READ;
      $display("Test search done");
   endtask
   task automatic t_gap;
      n_data = 0;
      n_blk = 0;
      repeat (4) u_tape_feed.send_frame(8'h55, 18'h0, 1'h0);
      check("gap_flags", n_data + n_blk, 0);
      check("gap_err", err, 0);
      n_data = 0;
      u_tape_feed.send_frame(8'h78, 18'h0, 1'h0);
      check("bad_tail_flags", n_data, 0);
      $display("Test gap done");
   endtask
   task automatic t_quiet;
      fmt = 1'h1;
      n_data = 0;
      u_tape_feed.send_frame(8'h38, wdat(2), 1'h0);
      check("fmt_flags", n_data, 0);
      fmt = 1'h0;
      sel = 1'h0;
      u_tape_feed.send_frame(8'hB6, 18'h0, 1'h0);
      check("desel_err", err, 0);
      check("desel_move", moving, 1);
      motion(1'h0, 1'h1);
      check("stopped", moving, 0);
      sel = 1'h1;
      $display("Test quiet done");
   endtask
   task automatic t_end;
      u_tape_feed.send_frame(8'h55, 18'h0, 1'h0);
      for (int p = 0; p < 3; p++) begin
         clear_err();
         motion(1'h0, 1'h0);
         u_tape_feed.send_frame(rev_end[p], 18'h0, 1'h0);
         check("far_end", err, 0);
         u_tape_feed.send_frame(fwd_end[p], 18'h0, 1'h0);
         check("end_err", err, 1);
         check("end_stop", moving, 0);
         clear_err();
         u_tape_feed.send_frame(fwd_end[p], 18'h0, 1'h0);
         check("coast_err", err, 0);
         motion(1'h1, 1'h0);
         u_tape_feed.send_frame(fwd_end[p], 18'h0, 1'h0);
         check("turn_err", err, 0);
         u_tape_feed.send_frame(rev_end[p], 18'h0, 1'h1);
         check("rev_end_err", err, 1);
      end
      clear_err();
      $display("Test end_zone done");
   endtask
   // fill buffer, then write words out
   task automatic t_write;
      int n = 0;
      logic ok;
      mode = tape_ctl_pkg::MODE_MOVE;
      wr_valid = 1'h1;
      repeat (6) begin
         wr_data = wdat(n);
         ok = wr_ready;
         @(posedge clock_i);
         #1;
         if (ok === 1'h1) n++;
      end
      wr_valid = 1'h0;
      check("fifo_count", n, 4);
      check("fifo_full", wr_ready, 0);
      mode = tape_ctl_pkg::MODE_WRITE;
      motion(1'h0, 1'h0);
      check("writers_on", wen, 1);
      for (int k = 0; k < 4; k++) begin
         u_tape_feed.send_frame(8'h38, 18'h0, 1'h0);
         for (int g = 0; g < 6; g++) begin
            check("write_lanes", wbits, wdat(k) >> (15 - 3 * g) & 18'h7);
            if (g < 5) u_tape_feed.send_bit(g[0], 3'h0);
         end
      end
      check("fifo_empty", wr_ready, 1);
      $display("Test write done");
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clock_i);
      #1 srst_i = 1'h0;
      t_read_fwd();
      t_read_rev();
      t_search();
      t_gap();
      t_quiet();
      t_end();
      t_write();
      give_verdict();
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clock_i);
      n_fail++;
      $display("BAD watchdog expected finish seen timeout");
      give_verdict();
   end
endmodule // tape_word_control_test
